// ### sppm_fifo.sv
// Small transmit queue with registered full and empty flags.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
module sppm_fifo
  import sppm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words
  logic [AW-1:0]    wp_q;            // Write pointer
  logic [AW-1:0]    rp_q;            // Read pointer
  logic [AW:0]      cnt_q;           // Words held
  logic             push;            // Word accepted
  logic             pop;             // Word drained
  logic [AW:0]      cnt_d;           // Next count

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_q[rp_q];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  // Pointers, count and flags
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != FULL_CNT;
      out_valid <= cnt_d != '0;
    end
  end
endmodule : sppm_fifo

// ### sppm_host.sv
// Far-side line model: sends one framed character on a line.
// Assumes the bench clock; line idles high.
`timescale 1ns/10ps
module sppm_host (
  input wire logic clk,
  output logic     line
);
  initial line = 1'b1;
  // Start, data LSB first, optional parity, one stop
  task automatic send(input logic [7:0] d, input int n, input logic pe, po, input int bc);
    logic q[$];
    logic x;
    x = po;
    q.push_back(1'b0);
    for (int i = 0; i < n; i++)
    begin
      q.push_back(d[i]);
      x ^= d[i];
    end
    if (pe) q.push_back(x);
    q.push_back(1'b1);
    foreach (q[i])
    begin
      @(posedge clk);
      #1 line = q[i];
      repeat (bc - 1) @(posedge clk);
    end
  endtask : send
endmodule : sppm_host

// ### sppm_pkg.sv
// Shared constants and types for the three-port serial block.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
package sppm_pkg;

  // ---------------------------------------------------------------
  // Clock and bit timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ    = 50_000_000;   // System clock rate
  localparam int          OVS       = 16;           // Ticks per bit
  localparam logic [3:0]  OVS_MID   = 4'h7;         // Mid start bit
  localparam logic [3:0]  OVS_LAST  = 4'hF;         // Last tick of a bit
  localparam int          IDLE_S    = 10;           // Locked-mode idle, s
  localparam longint      IDLE_CYC  = longint'(IDLE_S) * CLK_HZ;
  localparam int          NPORT     = 3;            // Port count
  localparam logic [2:0]  TWO_WIRE  = 3'h6;         // Ports two and three

  // ---------------------------------------------------------------
  // Bit rates in bit/s
  // ---------------------------------------------------------------
  localparam int R_110 = 110;
  localparam int R_150 = 150;
  localparam int R_300 = 300;
  localparam int R_600 = 600;
  localparam int R_1200 = 1200;
  localparam int R_2400 = 2400;
  localparam int R_4800 = 4800;
  localparam int R_9600 = 9600;
  localparam int R_19200 = 19200;
  localparam int R_31250 = 31250;
  localparam int R_38400 = 38400;
  localparam int R_57600 = 57600;
  localparam int R_100K = 100000;
  localparam int R_115K2 = 115200;
  localparam int R_230K4 = 230400;

  // ---------------------------------------------------------------
  // Line format byte layout
  // ---------------------------------------------------------------
  localparam int         FMT_SEVEN = 7;             // 1: seven data bits
  localparam int         FMT_PEN   = 6;             // 1: parity on
  localparam int         FMT_PODD  = 5;             // 1: odd parity
  localparam int         FMT_TWOST = 4;             // 1: two stop bits
  localparam logic [7:0] FMT_RESET = 8'h06;         // 38400 8-N-1

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0, MODE_HOST = 3'h1, MODE_MBA = 3'h2,
    MODE_MBR  = 3'h3, MODE_DIAL = 3'h4, MODE_NONE = 3'h5
  } sppm_mode_t;

  typedef enum logic [2:0] {
    BIT_IDLE = 3'h0, BIT_START = 3'h1, BIT_DATA = 3'h2,
    BIT_PAR  = 3'h3, BIT_STOP  = 3'h4
  } sppm_bit_t;

  // Tick divisor for one rate code
  function automatic logic [15:0] sppm_div(input logic [3:0] code);
    int r;
    case (code)
      4'h0, 4'h1: r = R_2400;
      4'h2:       r = R_4800;
      4'h3:       r = R_9600;
      4'h4:       r = R_19200;
      4'h5:       r = R_31250;
      4'h6:       r = R_38400;
      4'h7:       r = R_57600;
      4'h8:       r = R_100K;
      4'h9:       r = R_115K2;
      4'hA:       r = R_230K4;
      4'hB:       r = R_110;
      4'hC:       r = R_150;
      4'hD:       r = R_300;
      4'hE:       r = R_600;
      default:    r = R_1200;
    endcase
    return 16'(CLK_HZ / (OVS * r));
  endfunction : sppm_div

  // True for a protocol that a port can lock to
  function automatic logic sppm_is_proto(input logic [2:0] m);
    return (m >= MODE_HOST) && (m <= MODE_DIAL);
  endfunction : sppm_is_proto

endpackage : sppm_pkg

// ### sppm_ports.sv
// Three independent serial ports: framing, rate, receive store and
// protocol mode tracking. Assumes a 50 MHz clock, synchronous line
// inputs and an outside command parser.
//
// Overview of operation
// - Format byte: high nibble framing, low rate
// - Bit7 seven data bits; bit4 two stops
// - Bits6..5: none, even or odd parity
// - Rate codes 0..7: 2400 up to 57600
// - Rate codes 8..F: 100K..230.4K, 110..1200
// - Format survives soft reset; power reset reloads 06
// - Power-up format is 06: 38400 8-N-1
// - Each port owns its format and mode
// - Four protocols recognised and answered per port
// - Power-up mode is auto-detect on all ports
// - Recognised command locks port, checked per protocol
// - Other protocol commands dropped while locked
// - Locked mode returns to auto after 10 s
// - No-protocol selection: never answer commands
// - Fixed selection: no detect, no timeout
// - Halt switch set at power-up blocks format and mode writes
// - 256-byte circular receive store, overwrite oldest
// - Two-wire ports: driver on while sending, off after stop
`timescale 1ns/10ps
module sppm_ports
  import sppm_pkg::*;
#(
  parameter longint IDLE_CYCLES = IDLE_CYC
)(
  // Clock and resets
  clk,
  reset_n,
  soft_reset,
  halt_switch,
  // Configuration
  line_format_write,
  line_format_data,
  protocol_select_write,
  protocol_select_data,
  line_format,
  // Transmit queue
  tx_valid,
  tx_data,
  tx_ready,
  // Serial lines
  rxd,
  txd,
  drv_en,
  // Received character stream
  rx_char_valid,
  rx_char,
  rx_frame_err,
  rx_parity_err,
  // Receive store
  rx_read,
  rx_head,
  rx_avail,
  // Commands
  cmd_valid,
  cmd_proto,
  cmd_check_ok,
  cmd_exec,
  cmd_error,
  cmd_drop,
  mode
);
  // Clock and resets
  input  wire logic        clk;
  input  wire logic        reset_n;
  input  wire logic        soft_reset;
  input  wire logic        halt_switch;
  // Configuration
  input  wire logic [2:0]  line_format_write;
  input  wire logic [7:0]  line_format_data;
  input  wire logic [2:0]  protocol_select_write;
  input  wire logic [2:0]  protocol_select_data;
  output logic      [23:0] line_format;
  // Transmit queue
  input  wire logic [2:0]  tx_valid;
  input  wire logic [23:0] tx_data;
  output logic      [2:0]  tx_ready;
  // Serial lines
  input  wire logic [2:0]  rxd;
  output logic      [2:0]  txd;
  output logic      [2:0]  drv_en;
  // Received character stream
  output logic      [2:0]  rx_char_valid;
  output logic      [23:0] rx_char;
  output logic      [2:0]  rx_frame_err;
  output logic      [2:0]  rx_parity_err;
  // Receive store
  input  wire logic [2:0]  rx_read;
  output logic      [23:0] rx_head;
  output logic      [2:0]  rx_avail;
  // Commands
  input  wire logic [2:0]  cmd_valid;
  input  wire logic [8:0]  cmd_proto;
  input  wire logic [2:0]  cmd_check_ok;
  output logic      [2:0]  cmd_exec;
  output logic      [2:0]  cmd_error;
  output logic      [2:0]  cmd_drop;
  output logic      [8:0]  mode;

  // ---------------------------------------------------------------
  // Halt switch capture after reset release
  // ---------------------------------------------------------------
  logic armed_q;                   // Strap sampled
  logic halt_q;                    // Halt seen at power-up

  // Sample the switch once, on the first edge after release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      armed_q <= 1'b0;
      halt_q  <= 1'b0;
    end
    else if (!armed_q)
    begin
      armed_q <= 1'b1;
      halt_q  <= halt_switch;
    end
  end

  // ---------------------------------------------------------------
  // Per-port logic
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    logic [7:0]  fmt_q;            // Written format
    logic [7:0]  cur_q;            // Format in use
    logic [15:0] div_q;            // Tick divider
    logic        tick_q;           // Oversample tick
    logic        seven;            // Seven data bits
    logic        pen;              // Parity on
    logic        podd;             // Odd parity
    logic [2:0]  last_bit;         // Index of last data bit
    logic        q_vld;            // Queue word waiting
    logic [7:0]  q_dat;            // Queue head
    logic        q_pop;            // Take queue head
    sppm_bit_t   tst_q;            // Transmit state
    logic [3:0]  tov_q;            // Transmit tick count
    logic [2:0]  tcnt_q;           // Transmit bit count
    logic [7:0]  tsh_q;            // Transmit shifter
    logic        tpar_q;           // Transmit parity
    sppm_bit_t   rst_q;            // Receive state
    logic [3:0]  rov_q;            // Receive tick count
    logic [2:0]  rcnt_q;           // Receive bit count
    logic [7:0]  rsh_q;            // Receive shifter
    logic        rpar_q;           // Receive parity
    logic        perr_q;           // Parity fault of this char
    logic        rbit;             // Sampling instant
    logic        rdone;            // Character complete
    logic [7:0]  rchar;            // Completed character
    logic [7:0]  buf_q [256];      // Receive store
    logic [7:0]  wp_q;             // Store write pointer
    logic [7:0]  rp_q;             // Store read pointer
    logic [8:0]  cnt_q;            // Store fill

    assign seven    = cur_q[FMT_SEVEN];
    assign pen      = cur_q[FMT_PEN];
    assign podd     = cur_q[FMT_PODD];
    assign last_bit = seven ? 3'h6 : 3'h7;
    assign q_pop    = (tst_q == BIT_IDLE) && q_vld;
    assign rbit     = tick_q && (rov_q == OVS_LAST);
    assign rdone    = rbit && (rst_q == BIT_STOP);
    assign rchar    = seven ? {1'b0, rsh_q[7:1]} : rsh_q;

    // Format register, kept over soft reset
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        fmt_q <= FMT_RESET;
      else if (line_format_write[i] && armed_q && !halt_q)
        fmt_q <= line_format_data;
    end

    // Apply format only when both directions are idle
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        cur_q <= FMT_RESET;
      else if (tst_q == BIT_IDLE && rst_q == BIT_IDLE && !q_vld)
        cur_q <= fmt_q;
    end

    // Rate divider making the oversample tick
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        div_q  <= '0;
        tick_q <= 1'b0;
      end
      else if (div_q == '0)
      begin
        div_q  <= sppm_div(cur_q[3:0]) - 16'h1;
        tick_q <= 1'b1;
      end
      else
      begin
        div_q  <= div_q - 16'h1;
        tick_q <= 1'b0;
      end
    end

    // Transmit queue
    sppm_fifo #(.WIDTH(8), .DEPTH(4)) u_txq (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (tx_valid[i]),
      .in_data   (tx_data[8*i +: 8]),
      .in_ready  (tx_ready[i]),
      .out_valid (q_vld),
      .out_data  (q_dat),
      .out_ready (q_pop)
    );

    // Transmit sequencer
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        tst_q  <= BIT_IDLE;
        tov_q  <= '0;
        tcnt_q <= '0;
        tsh_q  <= '0;
        tpar_q <= 1'b0;
        txd[i] <= 1'b1;
      end
      else if (tst_q == BIT_IDLE)
      begin
        txd[i] <= 1'b1;
        if (q_pop)
        begin
          tsh_q  <= q_dat;
          tpar_q <= 1'b0;
          tov_q  <= '0;
          tst_q  <= BIT_START;
          txd[i] <= 1'b0;
        end
      end
      else if (tick_q)
      begin
        tov_q <= tov_q + 4'h1;
        if (tov_q == OVS_LAST)
        begin
          case (tst_q)
            BIT_START:
            begin
              tcnt_q <= '0;
              txd[i] <= tsh_q[0];
              tst_q  <= BIT_DATA;
            end
            BIT_DATA:
            begin
              tpar_q <= tpar_q ^ tsh_q[0];
              tsh_q  <= {1'b0, tsh_q[7:1]};
              tcnt_q <= tcnt_q + 3'h1;
              txd[i] <= tsh_q[1];
              if (tcnt_q == last_bit)
              begin
                tcnt_q <= '0;
                tst_q  <= pen ? BIT_PAR : BIT_STOP;
                txd[i] <= pen ? (tpar_q ^ tsh_q[0] ^ podd) : 1'b1;
              end
            end
            BIT_PAR:
            begin
              txd[i] <= 1'b1;
              tst_q  <= BIT_STOP;
            end
            BIT_STOP:
            begin
              if (cur_q[FMT_TWOST] && tcnt_q == '0)
                tcnt_q <= 3'h1;
              else
                tst_q <= BIT_IDLE;
            end
            default: tst_q <= BIT_IDLE;
          endcase
        end
      end
    end

    // Line driver enable on two-wire ports
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        drv_en[i] <= 1'b0;
      else
        drv_en[i] <= TWO_WIRE[i] && (tst_q != BIT_IDLE || q_vld);
    end

    // Receive sequencer, sampling mid-bit
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        rst_q  <= BIT_IDLE;
        rov_q  <= '0;
        rcnt_q <= '0;
        rsh_q  <= '0;
        rpar_q <= 1'b0;
        perr_q <= 1'b0;
      end
      else if (tick_q)
      begin
        rov_q <= rov_q + 4'h1;
        case (rst_q)
          BIT_IDLE:
          begin
            rov_q <= '0;
            if (!rxd[i])
              rst_q <= BIT_START;
          end
          BIT_START:
          begin
            if (rov_q == OVS_MID)
            begin
              rov_q  <= '0;
              rcnt_q <= '0;
              rpar_q <= 1'b0;
              perr_q <= 1'b0;
              rst_q  <= rxd[i] ? BIT_IDLE : BIT_DATA;
            end
          end
          BIT_DATA:
          begin
            if (rbit)
            begin
              rsh_q  <= {rxd[i], rsh_q[7:1]};
              rpar_q <= rpar_q ^ rxd[i];
              rcnt_q <= rcnt_q + 3'h1;
              if (rcnt_q == last_bit)
                rst_q <= pen ? BIT_PAR : BIT_STOP;
            end
          end
          BIT_PAR:
          begin
            if (rbit)
            begin
              perr_q <= rpar_q ^ rxd[i] ^ podd;
              rst_q  <= BIT_STOP;
            end
          end
          BIT_STOP:
          begin
            if (rbit)
              rst_q <= BIT_IDLE;
          end
          default: rst_q <= BIT_IDLE;
        endcase
      end
    end

    // Character stream to the command parser
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        rx_char_valid[i]  <= 1'b0;
        rx_char[8*i +: 8] <= '0;
        rx_frame_err[i]   <= 1'b0;
        rx_parity_err[i]  <= 1'b0;
      end
      else
      begin
        rx_char_valid[i] <= rdone;
        if (rdone)
        begin
          rx_char[8*i +: 8] <= rchar;
          rx_frame_err[i]   <= !rxd[i];
          rx_parity_err[i]  <= perr_q;
        end
      end
    end

    // Receive store write
    always_ff @(posedge clk)
    begin
      if (rdone)
        buf_q[wp_q] <= rchar;
    end

    // Receive store pointers; a full store drops its oldest byte
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end
      else
      begin
        if (rdone)
          wp_q <= wp_q + 8'h1;
        if ((rdone && cnt_q[8]) || (rx_read[i] && rx_avail[i] && cnt_q != '0))
          rp_q <= rp_q + 8'h1;
        if (rdone && !cnt_q[8] && !(rx_read[i] && rx_avail[i]))
          cnt_q <= cnt_q + 9'h1;
        else if (!rdone && rx_read[i] && rx_avail[i] && cnt_q != '0)
          cnt_q <= cnt_q - 9'h1;
      end
    end

    // Store head and fill flag, aligned to each other
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        rx_head[8*i +: 8] <= '0;
        rx_avail[i]       <= 1'b0;
      end
      else
      begin
        rx_head[8*i +: 8] <= buf_q[rp_q];
        rx_avail[i]       <= cnt_q != '0;
      end
    end

    // Visible format
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        line_format[8*i +: 8] <= FMT_RESET;
      else
        line_format[8*i +: 8] <= fmt_q;
    end

    // Protocol tracker
    sppm_proto #(.IDLE_CYCLES(IDLE_CYCLES)) u_proto (
      .clk          (clk),
      .reset_n      (reset_n),
      .soft_reset   (soft_reset),
      .sel_write    (protocol_select_write[i] && armed_q && !halt_q),
      .sel_data     (protocol_select_data),
      .cmd_valid    (cmd_valid[i]),
      .cmd_proto    (cmd_proto[3*i +: 3]),
      .cmd_check_ok (cmd_check_ok[i]),
      .cmd_exec     (cmd_exec[i]),
      .cmd_error    (cmd_error[i]),
      .cmd_drop     (cmd_drop[i]),
      .mode         (mode[3*i +: 3])
    );
  end
endmodule : sppm_ports

// ### sppm_properties.sv
// Checker for the three-port serial block, watching top ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module sppm_props (
  input wire logic clk, reset_n,
  input wire logic [2:0] line_format_write, cmd_valid, cmd_check_ok, cmd_exec,
  input wire logic [2:0] cmd_error, cmd_drop, txd, drv_en, rx_char_valid,
  input wire logic [23:0] line_format,
  input wire logic [8:0] cmd_proto, mode
);
  logic [2:0] m, p;
  assign m = mode[2:0];
  assign p = cmd_proto[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_drv; !drv_en[0]; endproperty
  a_drv: assert property (p_drv) else $error("port one driver on");
  property p_de; $fell(txd[1]) |-> drv_en[1]; endproperty
  a_de: assert property (p_de) else $error("driver off at start");
  property p_one; cmd_valid[0] |=> $onehot({cmd_exec[0], cmd_error[0], cmd_drop[0]}); endproperty
  a_one: assert property (p_one) else $error("not one verdict");
  property p_lock; m == 3'h0 && cmd_valid[0] && cmd_check_ok[0] && p inside {[1:4]}
    |=> cmd_exec[0] ##1 m == $past(p, 2); endproperty
  a_lock: assert property (p_lock) else $error("no lock");
  property p_oth; m inside {[1:4]} && cmd_valid[0] && p != m |=> cmd_drop[0]; endproperty
  a_oth: assert property (p_oth) else $error("other kept");
  property p_err; m inside {[1:4]} && cmd_valid[0] && p == m && !cmd_check_ok[0]
    |=> cmd_error[0]; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_none; m == 3'h5 && cmd_valid[0] |=> cmd_drop[0]; endproperty
  a_none: assert property (p_none) else $error("none answered");
  property p_fmt; $changed(line_format[15:8]) |-> $past(line_format_write[1], 2); endproperty
  a_fmt: assert property (p_fmt) else $error("format moved");
  property p_rx; rx_char_valid[1] |=> !rx_char_valid[1]; endproperty
  a_rx: assert property (p_rx) else $error("long pulse");
  cover property (cmd_exec[0]);
  cover property ($fell(txd[2]));
  cover property (rx_char_valid[1]);
endmodule : sppm_props
bind sppm_ports sppm_props u_sppm_props (.*);

// ### sppm_proto.sv
// Protocol mode tracker for one serial port.
// Assumes an outside parser reports each complete command with its
// protocol and whether its check field matched.
`timescale 1ns/10ps
module sppm_proto
  import sppm_pkg::*;
#(
  parameter longint IDLE_CYCLES = IDLE_CYC
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       soft_reset,
  // Selection
  input  wire logic       sel_write,
  input  wire logic [2:0] sel_data,
  // Parsed commands
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_proto,
  input  wire logic       cmd_check_ok,
  // Verdicts and state
  output logic            cmd_exec,
  output logic            cmd_error,
  output logic            cmd_drop,
  output logic [2:0]      mode
);
  sppm_mode_t  sel_q;              // Selected behaviour
  sppm_mode_t  mode_q;             // Current mode
  logic [31:0] idle_q;             // Quiet time counter
  logic        sel_ok;             // Selection code usable
  logic        timeout;            // Quiet limit reached
  logic        exec_d;             // Command accepted
  logic        err_d;              // Own protocol, bad check

  assign sel_ok  = sel_write && (sel_data <= MODE_NONE);
  assign timeout = sppm_is_proto(mode_q) && (sel_q == MODE_AUTO)
                   && (idle_q == 32'(IDLE_CYCLES - 1));
  assign exec_d  = cmd_valid && sppm_is_proto(cmd_proto) && cmd_check_ok
                   && ((mode_q == cmd_proto) || (mode_q == MODE_AUTO));
  assign err_d   = cmd_valid && sppm_is_proto(mode_q)
                   && (mode_q == cmd_proto) && !cmd_check_ok;
  assign mode    = mode_q;

  // Selection register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sel_q <= MODE_AUTO;
    else if (sel_ok)
      sel_q <= sppm_mode_t'(sel_data);
  end

  // Mode: select, restore, lock, time out
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      mode_q <= MODE_AUTO;
    else if (sel_ok)
      mode_q <= sppm_mode_t'(sel_data);
    else if (soft_reset)
      mode_q <= sel_q;
    else if (exec_d && mode_q == MODE_AUTO)
      mode_q <= sppm_mode_t'(cmd_proto);
    else if (timeout)
      mode_q <= MODE_AUTO;
  end

  // Quiet timer, only while auto-locked
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      idle_q <= '0;
    else if (cmd_valid || timeout || !sppm_is_proto(mode_q) || sel_q != MODE_AUTO)
      idle_q <= '0;
    else
      idle_q <= idle_q + 32'h1;
  end

  // Registered verdicts
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cmd_exec  <= 1'b0;
      cmd_error <= 1'b0;
      cmd_drop  <= 1'b0;
    end
    else
    begin
      cmd_exec  <= exec_d;
      cmd_error <= err_d;
      cmd_drop  <= cmd_valid && !exec_d && !err_d;
    end
  end
endmodule : sppm_proto

// ### test_sppm_ports.sv
// Self-checking bench for the three-port serial block.
// Assumes package, queue, tracker, ports and host model compiled first.
`timescale 1ns/10ps
module test_sppm_ports;
  import sppm_pkg::*;
  logic clk, reset_n, sr, hs;
  logic [2:0] fw, pw, tv, rd, cv, ok, pd;
  logic [7:0] fd;
  logic [23:0] td;
  logic [8:0] cp;
  wire logic hl;
  wire logic [2:0] rxd, tr, txd, de, rv, fe, pe, ra, ce, cr, cd;
  wire logic [23:0] lf, rc, rh;
  wire logic [8:0] md;
  int miscompares, total_checks;
  assign rxd = {1'b1, hl, 1'b1};
  sppm_ports #(.IDLE_CYCLES(200)) u_sppm_ports (.clk(clk), .reset_n(reset_n),
    .soft_reset(sr), .halt_switch(hs), .line_format_write(fw), .line_format_data(fd),
    .protocol_select_write(pw), .protocol_select_data(pd), .line_format(lf),
    .tx_valid(tv), .tx_data(td), .tx_ready(tr), .rxd(rxd), .txd(txd), .drv_en(de),
    .rx_char_valid(rv), .rx_char(rc), .rx_frame_err(fe), .rx_parity_err(pe),
    .rx_read(rd), .rx_head(rh), .rx_avail(ra), .cmd_valid(cv), .cmd_proto(cp),
    .cmd_check_ok(ok), .cmd_exec(ce), .cmd_error(cr), .cmd_drop(cd), .mode(md));
  sppm_host u_sppm_host (.clk(clk), .line(hl));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task cyc(input int n); repeat (n) @(posedge clk); #1; endtask : cyc
  task chk(input string s, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task wr(input int i, input logic [7:0] v);
    fw[i] = 1'b1; fd = v; cyc(1); fw = 3'h0; cyc(2);
  endtask : wr
  task cmd(input logic [2:0] p, input logic o, output logic [2:0] v);
    // Verdict stands for one cycle only: take it right after the edge
    cv[0] = 1'b1; cp[2:0] = p; ok[0] = o; cyc(1); v = {ce[0], cr[0], cd[0]};
    cv = 3'h0; cyc(1);
  endtask : cmd
  task sel(input logic [2:0] v); pw[0] = 1'b1; pd = v; cyc(1); pw = 3'h0; cyc(1); endtask : sel
  task t_cfg;
    chk("fmt", 16'h0606, lf[23:8]); chk("mode", 9'h0, md); chk("de", 3'h0, de);
    wr(1, 8'hEA); wr(2, 8'h1A); sr = 1'b1; cyc(1); sr = 1'b0; cyc(2);
    chk("fmt", 16'h1AEA, lf[23:8]); chk("fmt0", 8'h06, lf[7:0]);
    $display("t_cfg done");
  endtask : t_cfg
  task t_cmd;
    logic [2:0] v;
    cmd(3'h3, 1'b1, v); chk("exec", 3'h4, v); cyc(1); chk("lock", 3'h3, md[2:0]);
    cmd(3'h1, 1'b1, v); chk("other", 3'h1, v);
    cmd(3'h3, 1'b0, v); chk("bad", 3'h2, v);
    cyc(205); chk("idle", 3'h0, md[2:0]);
    sel(3'h5); cmd(3'h2, 1'b1, v); chk("none", 3'h1, v);
    sel(3'h2); cyc(300); chk("fixed", 3'h2, md[2:0]);
    cmd(3'h4, 1'b1, v); chk("fixdrop", 3'h1, v);
    $display("t_cmd done");
  endtask : t_cmd
  task t_tx;
    logic [9:0] f;
    int n;
    f = {1'b1, ~(^7'h35), 7'h35, 1'b0};
    tv[1] = 1'b1; td[15:8] = 8'h35; cyc(1); tv = 3'h0;
    for (n = 0; n < 300 && txd[1]; n++) cyc(1);
    chk("de_on", 1'b1, de[1]); cyc(104);
    for (int i = 0; i < 10; i++) begin chk("bit", f[i], txd[1]); cyc(208); end
    chk("de_off", 1'b0, de[1]);
    for (n = 0; n < 8 && tr[2]; n++) begin tv[2] = 1'b1; cyc(1); end
    tv = 3'h0; chk("full", 1'b1, n inside {4, 5});
    for (n = 0; n < 15000 && de[2]; n++) cyc(1);
    // Five 8-N-2 characters: 11 bits of 208 cycles, start short by a tick
    chk("len", 1'b1, n > 11300 && n < 11500);
    cyc(2); chk("drain", 2'h1, {de[2], tr[2]});
    $display("t_tx done");
  endtask : t_tx
  task t_rx(input logic po, input logic e);
    int n;
    // Line runs alongside, so the one-cycle valid pulse is caught
    fork u_sppm_host.send(8'h5A, 7, 1'b1, po, 208); join_none
    for (n = 0; n < 3000 && !rv[1]; n++) cyc(1);
    chk("valid", 1'b1, rv[1]);
    chk("rx", 9'h05A, {pe[1], rc[15:8]} ^ {e, 8'h0});
    cyc(3); chk("avail", 1'b1, ra[1]); chk("head", 8'h5A, rh[15:8]);
    rd[1] = 1'b1; cyc(1); rd = 3'h0; cyc(3); chk("pop", 9'h0, {ra[1], fe[1]});
    wait fork; cyc(1);
    $display("t_rx done");
  endtask : t_rx
  // Power reset with the halt switch on: later writes are refused
  task t_halt;
    hs = 1'b1; reset_n = 1'b0; cyc(2); reset_n = 1'b1; cyc(2);
    chk("idle_out", 6'h07, {de, txd});
    wr(0, 8'h1F); sel(3'h5); hs = 1'b0; cyc(2);
    chk("halt", 11'h006, {md[2:0], lf[7:0]});
    $display("t_halt done");
  endtask : t_halt
  initial
  begin
    {reset_n, sr, hs, fw, pw, tv, rd, cv, ok, pd, fd, td, cp} = '0;
    cyc(16); reset_n = 1'b1; cyc(2);
    t_cfg(); t_cmd(); t_tx(); t_rx(1'b1, 1'b0); t_rx(1'b0, 1'b1); t_halt();
    finish_test();
  end
  initial begin #1ms; miscompares++; finish_test(); end
endmodule : test_sppm_ports
